// File: spfc_defines.svh
`ifndef SPFC_DEFINES_SVH
`define SPFC_DEFINES_SVH

// ----------------------------------------
// Clock and line rates
// ----------------------------------------
`define SPFC_CLK_HZ 100000000
`define SPFC_BAUD_0 1200
`define SPFC_BAUD_1 2400
`define SPFC_BAUD_2 4800
`define SPFC_BAUD_3 9600
`define SPFC_BAUD_4 19200
`define SPFC_BAUD_5 38400
`define SPFC_BAUD_6 57600
`define SPFC_BAUD_7 115200
`define SPFC_DIV_W 17
`define SPFC_FRAME_BITS 4'h9

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SPFC_ADDR_CFG 8'h00
`define SPFC_ADDR_TXDATA 8'h04
`define SPFC_ADDR_RXDATA 8'h08
`define SPFC_ADDR_STATUS 8'h0C

// ----------------------------------------
// Config fields and reset value
// ----------------------------------------
`define SPFC_CFG_PAR_LO 0
`define SPFC_CFG_PAR_HI 1
`define SPFC_CFG_FLOW_LO 2
`define SPFC_CFG_FLOW_HI 4
`define SPFC_CFG_BAUD_LO 5
`define SPFC_CFG_BAUD_HI 7
`define SPFC_CFG_SER 8
`define SPFC_CFG_RESET 9'h0C4

// ----------------------------------------
// Status fields
// ----------------------------------------
`define SPFC_ST_TXFULL 0
`define SPFC_ST_HALT 1
`define SPFC_ST_PERR 2
`define SPFC_ST_FERR 3
`define SPFC_ST_OVR 4

// ----------------------------------------
// Receive buffer and control characters
// ----------------------------------------
`define SPFC_RX_DEPTH 128
`define SPFC_RX_HIWATER 8'h64
`define SPFC_RX_FULL 8'h80
`define SPFC_XON 8'h11
`define SPFC_XOFF 8'h13

`endif

// File: spfc_pkg.sv
package spfc_pkg;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_EVEN = 2'h1,
    PAR_ODD = 2'h2
  } spfc_parity_type;

  typedef enum logic [2:0] {
    FLOW_NONE = 3'h0,
    FLOW_XON = 3'h1,
    FLOW_DTR_DSR = 3'h2,
    FLOW_RTS_CTS = 3'h3,
    FLOW_MODEM = 3'h4
  } spfc_flow_type;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } spfc_tx_state_type;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_START = 3'b010,
    RX_DATA = 3'b100
  } spfc_rx_state_type;

endpackage

// File: spfc_top.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "spfc_defines.svh"
module spfc_top
  import spfc_pkg::*;
#(
  parameter int CLK_HZ = `SPFC_CLK_HZ
)
(
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Register port
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR_STB,
  input wire logic RD_STB,
  output logic [15:0] RDATA,
  // Instrument control
  input wire logic LOCAL_PANEL,
  input wire logic FACTORY_RESET,
  input wire logic PRESET,
  // Serial line
  input wire logic RXD,
  input wire logic DSR,
  input wire logic CTS,
  output logic TXD,
  output logic DTR,
  output logic RTS
);

  // ----------------------------------------
  // Functions
  // ----------------------------------------
  function automatic logic [`SPFC_DIV_W-1:0] baud_div(input logic [2:0] sel);
    int rate;
    rate = `SPFC_BAUD_6;
    unique case (sel)
      3'h0: rate = `SPFC_BAUD_0;
      3'h1: rate = `SPFC_BAUD_1;
      3'h2: rate = `SPFC_BAUD_2;
      3'h3: rate = `SPFC_BAUD_3;
      3'h4: rate = `SPFC_BAUD_4;
      3'h5: rate = `SPFC_BAUD_5;
      3'h6: rate = `SPFC_BAUD_6;
      3'h7: rate = `SPFC_BAUD_7;
    endcase
    return `SPFC_DIV_W'(CLK_HZ / rate);
  endfunction

  // Frame in send order from bit 0: start, data LSB first, parity if set, stop
  function automatic logic [9:0] make_frame(input logic [7:0] d, input logic [1:0] par);
    logic [9:0] f;
    f = {1'b1, d, 1'b0};
    if (par == PAR_EVEN)
      f = {1'b1, ^d[6:0], d[6:0], 1'b0};
    else if (par == PAR_ODD)
      f = {1'b1, ~^d[6:0], d[6:0], 1'b0};
    return f;
  endfunction

  function automatic logic is_flow_char(input logic [7:0] c);
    return (c == `SPFC_XON) || (c == `SPFC_XOFF);
  endfunction

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  // Held across FACTORY_RESET and PRESET; RST stands for power-up and loads the fixed SPFC_CFG_RESET value
  logic [8:0] cfg_reg, cfg_next;
  logic [1:0] par;
  spfc_flow_type flow;
  logic ser_sel;
  logic [`SPFC_DIV_W-1:0] div;
  logic cfg_wr;

  assign par = cfg_reg[`SPFC_CFG_PAR_HI:`SPFC_CFG_PAR_LO];
  assign flow = spfc_flow_type'(cfg_reg[`SPFC_CFG_FLOW_HI:`SPFC_CFG_FLOW_LO]);
  assign ser_sel = cfg_reg[`SPFC_CFG_SER];
  assign div = baud_div(cfg_reg[`SPFC_CFG_BAUD_HI:`SPFC_CFG_BAUD_LO]);
  assign cfg_wr = WR_STB && (ADDR == `SPFC_ADDR_CFG) && LOCAL_PANEL;

  always_comb
  begin
    cfg_next = cfg_reg;
    if (cfg_wr)
      cfg_next = WDATA[8:0];
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      cfg_reg <= `SPFC_CFG_RESET;
    else
      cfg_reg <= cfg_next;
  end

  // ----------------------------------------
  // Receiver and buffer
  // ----------------------------------------
  spfc_rx_state_type rx_state_reg, rx_state_next;
  logic [`SPFC_DIV_W-1:0] rx_cnt_reg, rx_cnt_next;
  logic [3:0] rx_bit_reg, rx_bit_next;
  logic [7:0] rx_sr_reg, rx_sr_next;
  logic [6:0] rx_wr_reg, rx_wr_next, rx_rd_reg, rx_rd_next;
  logic [7:0] rx_count_reg, rx_count_next;
  logic halt_reg, halt_next;
  logic perr_reg, perr_next, ferr_reg, ferr_next, ovr_reg, ovr_next;
  logic [7:0] rx_mem [0:`SPFC_RX_DEPTH-1];
  logic rx_done, rx_perr, rx_store, rx_pop, flush, clr_wr;
  logic [7:0] rx_char;

  assign flush = FACTORY_RESET || PRESET;
  assign rx_pop = RD_STB && (ADDR == `SPFC_ADDR_RXDATA) && (rx_count_reg != 8'h00);
  assign clr_wr = WR_STB && (ADDR == `SPFC_ADDR_STATUS);
  assign rx_char = (par == PAR_NONE) ? rx_sr_reg : {1'b0, rx_sr_reg[6:0]};
  assign rx_perr = (par == PAR_EVEN) ? ^rx_sr_reg : (par == PAR_ODD) ? ~^rx_sr_reg : 1'b0;
  assign rx_store = rx_done && !(flow == FLOW_XON && is_flow_char(rx_char));

  always_comb
  begin
    rx_state_next = rx_state_reg;
    rx_cnt_next = rx_cnt_reg;
    rx_bit_next = rx_bit_reg;
    rx_sr_next = rx_sr_reg;
    rx_done = 1'b0;
    unique case (rx_state_reg)
      RX_IDLE:
        if (!RXD && ser_sel)
        begin
          rx_state_next = RX_START;
          rx_cnt_next = div >> 1;
        end
      RX_START:
        if (rx_cnt_reg == '0)
        begin
          // A glitch shorter than half a bit is not a start
          rx_state_next = RXD ? RX_IDLE : RX_DATA;
          rx_cnt_next = div - 1'b1;
          rx_bit_next = 4'h0;
        end
        else
          rx_cnt_next = rx_cnt_reg - 1'b1;
      RX_DATA:
        if (rx_cnt_reg == '0)
        begin
          rx_cnt_next = div - 1'b1;
          rx_bit_next = rx_bit_reg + 4'h1;
          if (rx_bit_reg == 4'h8)
          begin
            rx_done = 1'b1;
            rx_state_next = RX_IDLE;
          end
          else
            rx_sr_next = {RXD, rx_sr_reg[7:1]};
        end
        else
          rx_cnt_next = rx_cnt_reg - 1'b1;
    endcase
  end

  always_comb
  begin
    rx_wr_next = rx_wr_reg;
    rx_rd_next = rx_rd_reg;
    rx_count_next = rx_count_reg;
    halt_next = halt_reg;
    perr_next = perr_reg && !(clr_wr && WDATA[`SPFC_ST_PERR]);
    ferr_next = ferr_reg && !(clr_wr && WDATA[`SPFC_ST_FERR]);
    ovr_next = ovr_reg && !(clr_wr && WDATA[`SPFC_ST_OVR]);
    if (rx_done && rx_perr)
      perr_next = 1'b1;
    if (rx_done && !RXD)
      ferr_next = 1'b1;
    if (rx_done && flow == FLOW_XON && rx_char == `SPFC_XOFF)
      halt_next = 1'b1;
    else if (rx_done && flow == FLOW_XON && rx_char == `SPFC_XON)
      halt_next = 1'b0;
    if (flow != FLOW_XON)
      halt_next = 1'b0;
    if (rx_pop)
    begin
      rx_rd_next = rx_rd_reg + 7'h01;
      rx_count_next = rx_count_next - 8'h01;
    end
    if (rx_store && rx_count_reg == `SPFC_RX_FULL)
      ovr_next = 1'b1;
    else if (rx_store)
    begin
      rx_wr_next = rx_wr_reg + 7'h01;
      rx_count_next = rx_count_next + 8'h01;
    end
    if (flush)
    begin
      rx_wr_next = 7'h00;
      rx_rd_next = 7'h00;
      rx_count_next = 8'h00;
      halt_next = 1'b0;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= '0;
      rx_bit_reg <= 4'h0;
      rx_sr_reg <= 8'h00;
      rx_wr_reg <= 7'h00;
      rx_rd_reg <= 7'h00;
      rx_count_reg <= 8'h00;
      halt_reg <= 1'b0;
      perr_reg <= 1'b0;
      ferr_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end
    else
    begin
      rx_state_reg <= rx_state_next;
      rx_cnt_reg <= rx_cnt_next;
      rx_bit_reg <= rx_bit_next;
      rx_sr_reg <= rx_sr_next;
      rx_wr_reg <= rx_wr_next;
      rx_rd_reg <= rx_rd_next;
      rx_count_reg <= rx_count_next;
      halt_reg <= halt_next;
      perr_reg <= perr_next;
      ferr_reg <= ferr_next;
      ovr_reg <= ovr_next;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (rx_store && rx_count_reg != `SPFC_RX_FULL)
      rx_mem[rx_wr_reg] <= rx_char;
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  spfc_tx_state_type tx_state_reg, tx_state_next;
  logic [`SPFC_DIV_W-1:0] tx_cnt_reg, tx_cnt_next;
  logic [3:0] tx_bit_reg, tx_bit_next;
  logic [9:0] tx_sr_reg, tx_sr_next;
  logic [7:0] tx_hold_reg, tx_hold_next;
  logic tx_full_reg, tx_full_next, txd_reg, txd_next, tx_permit;

  // Gate checked only between characters, so a stop lands within one character
  always_comb
  begin
    tx_permit = 1'b1;
    unique case (flow)
      FLOW_XON: tx_permit = !halt_reg;
      FLOW_DTR_DSR: tx_permit = DSR;
      FLOW_RTS_CTS: tx_permit = CTS;
      FLOW_MODEM: tx_permit = CTS && DSR;
      default: tx_permit = 1'b1;
    endcase
  end

  always_comb
  begin
    tx_state_next = tx_state_reg;
    tx_cnt_next = tx_cnt_reg;
    tx_bit_next = tx_bit_reg;
    tx_sr_next = tx_sr_reg;
    tx_hold_next = tx_hold_reg;
    tx_full_next = tx_full_reg;
    txd_next = txd_reg;
    if (WR_STB && ADDR == `SPFC_ADDR_TXDATA && !tx_full_reg)
    begin
      tx_hold_next = WDATA[7:0];
      tx_full_next = 1'b1;
    end
    unique case (tx_state_reg)
      TX_IDLE:
      begin
        txd_next = 1'b1;
        if (tx_full_reg && tx_permit && ser_sel)
        begin
          tx_sr_next = make_frame(tx_hold_reg, par);
          tx_full_next = 1'b0;
          tx_bit_next = 4'h0;
          tx_cnt_next = div - 1'b1;
          tx_state_next = TX_SEND;
          txd_next = 1'b0;
        end
      end
      TX_SEND:
        if (tx_cnt_reg != '0)
          tx_cnt_next = tx_cnt_reg - 1'b1;
        else if (tx_bit_reg == `SPFC_FRAME_BITS)
        begin
          tx_state_next = TX_IDLE;
          txd_next = 1'b1;
        end
        else
        begin
          tx_bit_next = tx_bit_reg + 4'h1;
          tx_sr_next = tx_sr_reg >> 1;
          txd_next = tx_sr_reg[1];
          tx_cnt_next = div - 1'b1;
        end
    endcase
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tx_state_reg <= TX_IDLE;
      tx_cnt_reg <= '0;
      tx_bit_reg <= 4'h0;
      tx_sr_reg <= 10'h3FF;
      tx_hold_reg <= 8'h00;
      tx_full_reg <= 1'b0;
      txd_reg <= 1'b1;
    end
    else
    begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg <= tx_cnt_next;
      tx_bit_reg <= tx_bit_next;
      tx_sr_reg <= tx_sr_next;
      tx_hold_reg <= tx_hold_next;
      tx_full_reg <= tx_full_next;
      txd_reg <= txd_next;
    end
  end

  // ----------------------------------------
  // Handshake lines and read port
  // ----------------------------------------
  logic dtr_reg, dtr_next, rts_reg, rts_next, room;
  logic [15:0] rdata_reg, rdata_next;

  assign room = rx_count_reg < `SPFC_RX_HIWATER;

  always_comb
  begin
    dtr_next = ser_sel;
    rts_next = ser_sel;
    if (flow == FLOW_DTR_DSR)
      dtr_next = ser_sel && room;
    if (flow == FLOW_RTS_CTS || flow == FLOW_MODEM)
      rts_next = ser_sel && room;
    rdata_next = 16'h0000;
    if (RD_STB)
    begin
      unique case (ADDR)
        `SPFC_ADDR_CFG: rdata_next = {7'h00, cfg_reg};
        `SPFC_ADDR_RXDATA: rdata_next = rx_pop ? {8'h00, rx_mem[rx_rd_reg]} : 16'h0000;
        `SPFC_ADDR_STATUS:
          rdata_next = {rx_count_reg, 3'h0, ovr_reg, ferr_reg, perr_reg, halt_reg, tx_full_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      dtr_reg <= 1'b0;
      rts_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end
    else
    begin
      dtr_reg <= dtr_next;
      rts_reg <= rts_next;
      rdata_reg <= rdata_next;
    end
  end

  assign TXD = txd_reg;
  assign DTR = dtr_reg;
  assign RTS = rts_reg;
  assign RDATA = rdata_reg;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  sequence s_launch;
    tx_state_reg == TX_IDLE ##1 tx_state_reg == TX_SEND;
  endsequence
  property p_start_bit;
    s_launch |-> !TXD ##1 !TXD;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("Start bit not low");
  property p_panel_only;
    WR_STB && ADDR == `SPFC_ADDR_CFG && !LOCAL_PANEL |=> $stable(cfg_reg);
  endproperty
  a_panel_only: assert property (p_panel_only) else $error("Config changed remotely");
  property p_keep_cfg;
    flush && !cfg_wr |=> $stable(cfg_reg);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg) else $error("Config lost on preset");
  property p_xoff;
    rx_done && flow == FLOW_XON && rx_char == `SPFC_XOFF && !flush |=> halt_reg;
  endproperty
  a_xoff: assert property (p_xoff) else $error("XOFF did not halt");
  property p_xon;
    rx_done && flow == FLOW_XON && rx_char == `SPFC_XON |=> !halt_reg;
  endproperty
  a_xon: assert property (p_xon) else $error("XON did not resume");
  property p_no_store;
    rx_done && flow == FLOW_XON && is_flow_char(rx_char) && !flush |=> $stable(rx_wr_reg);
  endproperty
  a_no_store: assert property (p_no_store) else $error("Flow char buffered");
  property p_dsr_gate;
    tx_state_reg == TX_IDLE && flow == FLOW_DTR_DSR && !DSR |=> tx_state_reg == TX_IDLE;
  endproperty
  a_dsr_gate: assert property (p_dsr_gate) else $error("Sent without DSR");
  property p_cts_gate;
    tx_state_reg == TX_IDLE && flow == FLOW_RTS_CTS && !CTS |=> tx_state_reg == TX_IDLE;
  endproperty
  a_cts_gate: assert property (p_cts_gate) else $error("Sent without CTS");
  property p_dtr_full;
    flow == FLOW_DTR_DSR && !room && !cfg_wr |=> !DTR ##1 (!DTR || $past(room));
  endproperty
  a_dtr_full: assert property (p_dtr_full) else $error("DTR high near full");
  property p_rts_full;
    (flow == FLOW_RTS_CTS || flow == FLOW_MODEM) && !room |=> !RTS;
  endproperty
  a_rts_full: assert property (p_rts_full) else $error("RTS high near full");
  property p_modem_dtr;
    flow == FLOW_MODEM && ser_sel |=> DTR;
  endproperty
  a_modem_dtr: assert property (p_modem_dtr) else $error("Modem DTR low");
  property p_none_go;
    flow == FLOW_NONE && ser_sel && tx_full_reg && tx_state_reg == TX_IDLE
      |=> tx_state_reg == TX_SEND;
  endproperty
  a_none_go: assert property (p_none_go) else $error("No-flow mode throttled");

endmodule

// File: spfc_host_model.sv
`timescale 1ns/100ps
module spfc_host_model
(
  // Clock
  input wire logic clk,
  // Line from the device, and the bit length from the bench
  input wire logic txd,
  input wire logic [15:0] bit_div,
  // Line and handshakes to the device
  output logic rxd,
  output logic dsr,
  output logic cts
);
  logic [9:0] last_frame;
  int got;
  int i;

  initial
  begin
    rxd = 1'b1;
    dsr = 1'b0;
    cts = 1'b0;
    got = 0;
    last_frame = '0;
  end

  // ----------------------------------------
  // Receiver: keeps start and stop too
  // ----------------------------------------
  always
  begin
    @(posedge clk);
    if (txd === 1'b0)
    begin
      repeat (bit_div / 2) @(posedge clk);
      for (i = 0; i < 10; i++)
      begin
        last_frame[i] = txd;
        if (i < 9)
          repeat (bit_div) @(posedge clk);
      end
      got++;
    end
  end

  // ----------------------------------------
  // Transmitter and handshake lines
  // ----------------------------------------
  // Raw frame, bit 0 first; line rests at mark
  task automatic send(input logic [9:0] f);
    int k;
    for (k = 0; k < 10; k++)
    begin
      @(posedge clk);
      rxd <= f[k];
      repeat (bit_div - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask

  task automatic set_lines(input logic d, input logic c);
    @(posedge clk);
    dsr <= d;
    cts <= c;
  endtask
endmodule

// File: spfc_top_tb_top.sv
`timescale 1ns/100ps
`include "spfc_defines.svh"
module spfc_top_tb_top
  import spfc_pkg::*;
;
  localparam int CLK_HZ = 1000000;
  typedef struct {
    logic [15:0] cfg;
    logic dsr;
    logic cts;
    logic dtr;
    logic rts;
    logic send;
    logic [7:0] b;
  } spfc_row_type;

  logic clk, rst, wr_stb, rd_stb, panel, fac_rst, preset;
  logic rxd, dsr, cts, txd, dtr, rts;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, rd_val, bit_div;
  int num_errors, n_checks, g0, i, r;
  int rates [8] = '{1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200};
  spfc_row_type rows [8];

  spfc_top #(.CLK_HZ(CLK_HZ)) spfc_top_inst (.CLK(clk), .RST(rst), .ADDR(addr),
    .WDATA(wdata), .WR_STB(wr_stb), .RD_STB(rd_stb), .RDATA(rdata),
    .LOCAL_PANEL(panel), .FACTORY_RESET(fac_rst), .PRESET(preset), .RXD(rxd),
    .DSR(dsr), .CTS(cts), .TXD(txd), .DTR(dtr), .RTS(rts));

  spfc_host_model spfc_host_model_inst (.clk(clk), .txd(txd), .bit_div(bit_div),
    .rxd(rxd), .dsr(dsr), .cts(cts));

  always #5 clk = ~clk;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [15:0] cfgv(spfc_parity_type p, spfc_flow_type f,
    logic [2:0] bd, logic s);
    return {7'h00, s, bd, f, p};
  endfunction

  function automatic logic [15:0] frame(logic [1:0] p, logic [7:0] b);
    if (p == PAR_NONE)
      return {6'h00, 1'b1, b, 1'b0};
    return {6'h00, 1'b1, (p == PAR_EVEN) ? ^b[6:0] : ~^b[6:0], b[6:0], 1'b0};
  endfunction

  task automatic summarize;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask

  // Data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 rd_val = rdata;
  endtask

  task automatic set_cfg(input logic [15:0] c);
    wr(`SPFC_ADDR_CFG, c);
    bit_div <= 16'(CLK_HZ / rates[c[7:5]]);
    repeat (2) @(posedge clk);
  endtask

  task automatic host_char(input logic [7:0] b);
    spfc_host_model_inst.send({1'b1, b, 1'b0});
    repeat (3) @(posedge clk);
  endtask

  // Bounded wait for a new frame after g0
  task automatic expect_frame(input logic [15:0] exp);
    int k;
    for (k = 0; k < 2500 && spfc_host_model_inst.got == g0; k++)
      @(posedge clk);
    if (spfc_host_model_inst.got == g0)
    begin
      num_errors++;
      summarize();
    end
    chk("frame", {6'h00, spfc_host_model_inst.last_frame}, exp);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    panel = 1'b1;
    fac_rst = 1'b0;
    preset = 1'b0;
    bit_div = 16'h0008;
    num_errors = 0;
    n_checks = 0;
    // Row 0, the one row without flow control, runs the host at 4800 baud
    rows[0] = '{cfgv(PAR_NONE, FLOW_NONE, 3'h2, 1'b1), 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 8'hA5};
    rows[1] = '{cfgv(PAR_EVEN, FLOW_DTR_DSR, 3'h7, 1'b1), 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 8'h35};
    rows[2] = '{cfgv(PAR_ODD, FLOW_DTR_DSR, 3'h7, 1'b1), 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 8'h4C};
    rows[3] = '{cfgv(PAR_NONE, FLOW_RTS_CTS, 3'h7, 1'b1), 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 8'hC3};
    rows[4] = '{cfgv(PAR_ODD, FLOW_RTS_CTS, 3'h7, 1'b1), 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h2B};
    rows[5] = '{cfgv(PAR_NONE, FLOW_MODEM, 3'h7, 1'b1), 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 8'h96};
    rows[6] = '{cfgv(PAR_NONE, FLOW_MODEM, 3'h7, 1'b1), 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 8'h01};
    rows[7] = '{cfgv(PAR_NONE, FLOW_XON, 3'h7, 1'b0), 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 8'h7F};
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    chk("dtr", 16'(dtr), 16'h0000);
    chk("rts", 16'(rts), 16'h0000);
    chk("txd", 16'(txd), 16'h0001);
    rd(`SPFC_ADDR_CFG);
    chk("cfg", rd_val, 16'h00C4);

    for (r = 0; r < 8; r++)
    begin
      spfc_host_model_inst.set_lines(rows[r].dsr, rows[r].cts);
      set_cfg(rows[r].cfg);
      chk("dtr", 16'(dtr), 16'(rows[r].dtr));
      chk("rts", 16'(rts), 16'(rows[r].rts));
      g0 = spfc_host_model_inst.got;
      wr(`SPFC_ADDR_TXDATA, {8'h00, rows[r].b});
      if (!rows[r].send)
      begin
        repeat (300) @(posedge clk);
        chk("held", 16'(spfc_host_model_inst.got), 16'(g0));
        spfc_host_model_inst.set_lines(1'b1, 1'b1);
        set_cfg(rows[r].cfg | 16'h0100);
      end
      expect_frame(frame(rows[r].cfg[1:0], rows[r].b));
    end

    // ----------------------------------------
    // Awkward cases
    // ----------------------------------------
    @(posedge clk);
    panel <= 1'b0;
    wr(`SPFC_ADDR_CFG, cfgv(PAR_ODD, FLOW_NONE, 3'h7, 1'b1));
    panel <= 1'b1;
    rd(`SPFC_ADDR_CFG);
    chk("cfg", rd_val, cfgv(PAR_NONE, FLOW_XON, 3'h7, 1'b1));

    host_char(`SPFC_XOFF);
    rd(`SPFC_ADDR_STATUS);
    chk("status", rd_val, 16'h0002);
    g0 = spfc_host_model_inst.got;
    wr(`SPFC_ADDR_TXDATA, 16'h005A);
    repeat (300) @(posedge clk);
    chk("halted", 16'(spfc_host_model_inst.got), 16'(g0));
    host_char(`SPFC_XON);
    expect_frame(frame(PAR_NONE, 8'h5A));
    rd(`SPFC_ADDR_STATUS);
    chk("status", rd_val, 16'h0000);

    // Fill the receive buffer up to the threshold
    set_cfg(cfgv(PAR_NONE, FLOW_DTR_DSR, 3'h7, 1'b1));
    for (i = 0; i < 99; i++)
      host_char(8'(i + 32));
    chk("dtr", 16'(dtr), 16'h0001);
    host_char(8'h7E);
    chk("dtr", 16'(dtr), 16'h0000);
    rd(`SPFC_ADDR_STATUS);
    chk("count", {8'h00, rd_val[15:8]}, 16'h0064);
    set_cfg(cfgv(PAR_NONE, FLOW_RTS_CTS, 3'h7, 1'b1));
    chk("rts", 16'(rts), 16'h0000);
    set_cfg(cfgv(PAR_NONE, FLOW_MODEM, 3'h7, 1'b1));
    chk("rts", 16'(rts), 16'h0000);
    chk("dtr", 16'(dtr), 16'h0001);
    rd(`SPFC_ADDR_RXDATA);
    chk("rxdata", rd_val, 16'h0020);
    repeat (2) @(posedge clk);
    chk("rts", 16'(rts), 16'h0001);

    // Factory reset, then preset: settings stay, buffer empties
    for (i = 0; i < 2; i++)
    begin
      @(posedge clk);
      fac_rst <= (i == 0);
      preset <= (i == 1);
      @(posedge clk);
      fac_rst <= 1'b0;
      preset <= 1'b0;
      rd(`SPFC_ADDR_CFG);
      chk("cfg", rd_val, cfgv(PAR_NONE, FLOW_MODEM, 3'h7, 1'b1));
      rd(`SPFC_ADDR_STATUS);
      chk("status", rd_val, 16'h0000);
    end

    // Seven-bit receive: bad parity, bad stop, clear, then overrun
    set_cfg(cfgv(PAR_EVEN, FLOW_NONE, 3'h7, 1'b1));
    spfc_host_model_inst.send({1'b1, 1'b1, 7'h41, 1'b0});
    spfc_host_model_inst.send({1'b0, 1'b0, 7'h41, 1'b0});
    rd(`SPFC_ADDR_STATUS);
    chk("status", rd_val, 16'h020C);
    rd(`SPFC_ADDR_RXDATA);
    chk("rxdata", rd_val, 16'h0041);
    wr(`SPFC_ADDR_STATUS, 16'h001C);
    rd(`SPFC_ADDR_STATUS);
    chk("status", rd_val, 16'h0100);
    for (i = 0; i < 128; i++)
      host_char(8'h30);
    rd(`SPFC_ADDR_STATUS);
    chk("status", rd_val, 16'h8010);
    rd(8'h10);
    chk("unmapped", rd_val, 16'h0000);
    @(posedge clk);
    #1 chk("rdata_idle", rdata, 16'h0000);

    // Reset in mid-run reloads the delivered settings
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    chk("dtr", 16'(dtr), 16'h0000);
    chk("rts", 16'(rts), 16'h0000);
    rd(`SPFC_ADDR_CFG);
    chk("cfg", rd_val, 16'h00C4);
    summarize();
  end
endmodule
